// ===== core/torque_limit_pkg.sv
/*
 * Constants, register map and carrier types for the torque command filter and limiter.
 * Assumes a 125 MHz hclk and torque values in signed 0.1 % of rated torque.
 */
// Operation
// - every torque command passes the low-pass filter before use, in all modes
// - each filter is first order, smoothing steps and ramps exponentially
// - two filters exist; the first is used unless gain switching picks another
// - gain switch enabled and condition nonzero: second filter while condition holds
// - first time constant 0 to 30.00 ms, default 0.79 ms, effective immediately
// - second time constant 0 to 30.00 ms, default 0.79 ms, effective immediately
// - the command limiter acts in every control mode
// - command magnitude above the limit gives the limit, else the command unchanged
// - exactly one positive and one negative limit are active at any time
// - active limits never exceed drive and motor maximum nor 300.0 percent
// - source 0 uses only the internal positive and negative limits
// - source 1: select inputs pick external when asserted, internal otherwise
// - source 2 takes both limits from the selected analog channel torque
// - source 3 positive: analog, or min of external and analog when selected
// - source 3 negative: analog, or min of external and analog when selected
// - source 4 positive: internal when deasserted, analog when asserted
// - source 4 negative: internal when deasserted, analog when asserted
// - internal and external limits range 0 to 300.0 percent, default 300.0
// - torque limited output is high while the command is held at the limit
package torque_limit_pkg;
	localparam int TORQUE_W = 16;
	localparam int LIMIT_W = 12;
	localparam int TC_W = 12;
	localparam int FRAC_W = 16;
	localparam int ACC_W = TORQUE_W + FRAC_W;
	localparam int DIV_STEPS = ACC_W + 1;

	localparam int CLK_PERIOD_PS = 8000;
	localparam int SAMPLE_TIME_PS = 10000000;
	localparam int SAMPLE_CYCLES = SAMPLE_TIME_PS / CLK_PERIOD_PS;

	localparam logic [LIMIT_W-1:0] LIMIT_CEILING = 12'hbb8;
	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 12'hbb8;
	localparam logic [TC_W-1:0] TC_MAX = 12'hbb8;
	localparam logic [TC_W-1:0] TC_RESET = 12'h04f;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FILT1_TC = 8'h04;
	localparam logic [7:0] ADDR_FILT2_TC = 8'h08;
	localparam logic [7:0] ADDR_INT_POS = 8'h0c;
	localparam logic [7:0] ADDR_INT_NEG = 8'h10;
	localparam logic [7:0] ADDR_EXT_POS = 8'h14;
	localparam logic [7:0] ADDR_EXT_NEG = 8'h18;
	localparam logic [7:0] ADDR_MAX_TORQUE = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_CMD_OUT = 8'h24;

	typedef enum logic [2:0] {
		SRC_INTERNAL = 3'h0,
		SRC_EXTERNAL = 3'h1,
		SRC_ANALOG = 3'h2,
		SRC_MIN_EXT_ANALOG = 3'h3,
		SRC_SWITCH_INT_ANALOG = 3'h4
	} limit_src_e;

	localparam logic [1:0] CHAN_ONE = 2'h1;
	localparam logic [1:0] CHAN_TWO = 2'h2;

	// ctrl word: [2:0] source, [5:4] channel, [8] gain enable, [15:12] condition
	typedef struct packed {
		logic [3:0] gain_switch_condition;
		logic [2:0] pad2;
		logic gain_switch_enable;
		logic [1:0] pad1;
		logic [1:0] analog_limit_channel_select;
		logic pad0;
		logic [2:0] limit_source_select;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '{gain_switch_condition: 4'h0, pad2: 3'h0,
		gain_switch_enable: 1'b0, pad1: 2'h0, analog_limit_channel_select: CHAN_TWO,
		pad0: 1'b0, limit_source_select: SRC_INTERNAL};

	typedef struct packed {
		logic [LIMIT_W-1:0] pos;
		logic [LIMIT_W-1:0] neg;
	} limit_pair_s;
endpackage

// ===== core/torque_cmd_filter_limiter.sv
/*
 * Torque command filter (two selectable first-order low-pass stages) and limiter
 * with five limit sources, registers on an AHB-Lite slave.
 * Assumes torque command, analog torque values and gain condition come from
 * hclk logic; the two limit-select inputs come from pins.
 */
`timescale 1ns/1ps
module torque_cmd_filter_limiter
	import torque_limit_pkg::*;
(
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic signed [torque_limit_pkg::TORQUE_W-1:0] torque_cmd_in, // raw command
	input wire logic signed [torque_limit_pkg::TORQUE_W-1:0] analog_input_one, // torque
	input wire logic signed [torque_limit_pkg::TORQUE_W-1:0] analog_input_two, // torque
	input wire logic positive_limit_select_in, // pin, active high
	input wire logic negative_limit_select_in, // pin, active high
	input wire logic gain_switch_cond_met, // switching condition holds
	output logic [3:0] gain_switch_condition_out, // code for the condition logic
	output logic signed [torque_limit_pkg::TORQUE_W-1:0] torque_cmd_out, // limited
	output logic torque_limited_out // command held at the limit
);
	import torque_limit_pkg::*;

	function automatic logic [LIMIT_W-1:0] min_lim(input logic [LIMIT_W-1:0] a,
		input logic [LIMIT_W-1:0] b);
		min_lim = (a < b) ? a : b;
	endfunction

	function automatic logic [LIMIT_W-1:0] clip_abs(
		input logic signed [TORQUE_W-1:0] v);
		logic [TORQUE_W-1:0] m;
		m = v[TORQUE_W-1] ? TORQUE_W'(-v) : TORQUE_W'(v);
		clip_abs = (m > TORQUE_W'(LIMIT_CEILING)) ? LIMIT_CEILING : m[LIMIT_W-1:0];
	endfunction

	// a write above the cap stores the cap, never just the low bits of the word
	function automatic logic [LIMIT_W-1:0] sat_word(input logic [31:0] d,
		input logic [LIMIT_W-1:0] cap);
		sat_word = (d > {20'h00000, cap}) ? cap : d[LIMIT_W-1:0];
	endfunction

	// register block
	ctrl_s ctrl_q;
	logic [TC_W-1:0] filt1_tc_q, filt2_tc_q;
	logic [LIMIT_W-1:0] int_pos_q, int_neg_q, ext_pos_q, ext_neg_q, max_torque_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic addr_hit;

	// synchronised select pins: [1] positive, [0] negative
	logic [1:0] sel_meta_q, sel_sync_q;

	// filter state
	logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt_q;
	logic tick;
	logic signed [TORQUE_W-1:0] x_cap_q;
	logic signed [ACC_W-1:0] y_q;
	logic f2_active_q;
	logic busy_q;
	logic [5:0] step_q;
	logic neg_q;
	logic [DIV_STEPS-1:0] quo_q;
	logic [LIMIT_W:0] rem_q;
	logic [TC_W:0] div_q;
	logic use_f2;
	logic signed [ACC_W:0] diff;
	logic [LIMIT_W+1:0] trial;
	logic signed [TORQUE_W-1:0] y_int;

	// limiter state
	limit_pair_s lim;
	logic [LIMIT_W-1:0] ceil_lim, analog_lim, int_pos_c, int_neg_c, ext_pos_c, ext_neg_c;
	logic signed [TORQUE_W-1:0] out_d;
	logic limited_d;
	logic signed [TORQUE_W-1:0] out_q;
	logic limited_q;

	assign addr_hit = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_hit && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
			filt1_tc_q <= TC_RESET;
			filt2_tc_q <= TC_RESET;
			int_pos_q <= LIMIT_RESET;
			int_neg_q <= LIMIT_RESET;
			ext_pos_q <= LIMIT_RESET;
			ext_neg_q <= LIMIT_RESET;
			max_torque_q <= LIMIT_CEILING;
		end else if (wr_pend_q) begin
			unique case (wr_addr_q)
				ADDR_CTRL: begin
					if (hwdata[2:0] <= SRC_SWITCH_INT_ANALOG) begin
						ctrl_q.limit_source_select <= hwdata[2:0];
					end
					if (hwdata[5:4] == CHAN_ONE || hwdata[5:4] == CHAN_TWO) begin
						ctrl_q.analog_limit_channel_select <= hwdata[5:4];
					end
					ctrl_q.gain_switch_enable <= hwdata[8];
					ctrl_q.gain_switch_condition <= hwdata[15:12];
				end
				ADDR_FILT1_TC: filt1_tc_q <= sat_word(hwdata, TC_MAX);
				ADDR_FILT2_TC: filt2_tc_q <= sat_word(hwdata, TC_MAX);
				ADDR_INT_POS: int_pos_q <= sat_word(hwdata, LIMIT_CEILING);
				ADDR_INT_NEG: int_neg_q <= sat_word(hwdata, LIMIT_CEILING);
				ADDR_EXT_POS: ext_pos_q <= sat_word(hwdata, LIMIT_CEILING);
				ADDR_EXT_NEG: ext_neg_q <= sat_word(hwdata, LIMIT_CEILING);
				ADDR_MAX_TORQUE: max_torque_q <= hwdata[LIMIT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else if (addr_hit && !hwrite) begin
			unique case (haddr[7:0])
				ADDR_CTRL: hrdata_q <= {16'h0000, ctrl_q};
				ADDR_FILT1_TC: hrdata_q <= {20'h00000, filt1_tc_q};
				ADDR_FILT2_TC: hrdata_q <= {20'h00000, filt2_tc_q};
				ADDR_INT_POS: hrdata_q <= {20'h00000, int_pos_q};
				ADDR_INT_NEG: hrdata_q <= {20'h00000, int_neg_q};
				ADDR_EXT_POS: hrdata_q <= {20'h00000, ext_pos_q};
				ADDR_EXT_NEG: hrdata_q <= {20'h00000, ext_neg_q};
				ADDR_MAX_TORQUE: hrdata_q <= {20'h00000, max_torque_q};
				ADDR_STATUS: hrdata_q <= {4'h0, lim.pos, 4'h0, sel_sync_q, f2_active_q,
					limited_q, 8'h00};
				ADDR_CMD_OUT: hrdata_q <= {{(32-TORQUE_W){out_q[TORQUE_W-1]}}, out_q};
				default: hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_meta_q <= 2'h0;
			sel_sync_q <= 2'h0;
		end else begin
			sel_meta_q <= {positive_limit_select_in, negative_limit_select_in};
			sel_sync_q <= sel_meta_q;
		end
	end

	// filter update every 10 us; the divider finishes long before the next tick
	assign tick = (tick_cnt_q == '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1);
		end else begin
			tick_cnt_q <= tick_cnt_q - 1'b1;
		end
	end

	assign use_f2 = ctrl_q.gain_switch_enable && (ctrl_q.gain_switch_condition != 4'h0)
		&& gain_switch_cond_met;
	assign diff = $signed({x_cap_q, {FRAC_W{1'b0}}}) - y_q;
	assign trial = {rem_q, quo_q[DIV_STEPS-1]};
	assign y_int = y_q[ACC_W-1:FRAC_W];

	// first order step: y += (x - y) / (tau + 1), tau in 10 us steps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			x_cap_q <= '0;
			f2_active_q <= 1'b0;
			div_q <= '0;
			busy_q <= 1'b0;
			step_q <= 6'h00;
			neg_q <= 1'b0;
			quo_q <= '0;
			rem_q <= '0;
		end else if (tick) begin
			x_cap_q <= torque_cmd_in;
			f2_active_q <= use_f2;
			div_q <= (use_f2 ? {1'b0, filt2_tc_q} : {1'b0, filt1_tc_q}) + 1'b1;
			busy_q <= 1'b0;
		end else if (!busy_q && step_q == 6'h00 && div_q != '0) begin
			busy_q <= 1'b1;
			step_q <= 6'(DIV_STEPS);
			neg_q <= diff[ACC_W];
			quo_q <= diff[ACC_W] ? DIV_STEPS'(-diff) : DIV_STEPS'(diff);
			rem_q <= '0;
		end else if (busy_q && step_q != 6'h00) begin
			step_q <= step_q - 1'b1;
			if (trial >= (LIMIT_W+2)'(div_q)) begin
				rem_q <= (LIMIT_W+1)'(trial - (LIMIT_W+2)'(div_q));
				quo_q <= {quo_q[DIV_STEPS-2:0], 1'b1};
			end else begin
				rem_q <= trial[LIMIT_W:0];
				quo_q <= {quo_q[DIV_STEPS-2:0], 1'b0};
			end
		end else if (busy_q) begin
			busy_q <= 1'b0;
			div_q <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			y_q <= '0;
		end else if (busy_q && step_q == 6'h00) begin
			y_q <= neg_q ? ACC_W'(y_q - $signed({1'b0, quo_q}))
				: ACC_W'(y_q + $signed({1'b0, quo_q}));
		end
	end

	// active limit pair, all sources clipped to the ceiling
	always_comb begin
		ceil_lim = min_lim(max_torque_q, LIMIT_CEILING);
		analog_lim = min_lim(clip_abs((ctrl_q.analog_limit_channel_select == CHAN_ONE)
			? analog_input_one : analog_input_two), ceil_lim);
		int_pos_c = min_lim(int_pos_q, ceil_lim);
		int_neg_c = min_lim(int_neg_q, ceil_lim);
		ext_pos_c = min_lim(ext_pos_q, ceil_lim);
		ext_neg_c = min_lim(ext_neg_q, ceil_lim);
		unique case (ctrl_q.limit_source_select)
			SRC_INTERNAL: lim = '{pos: int_pos_c, neg: int_neg_c};
			SRC_EXTERNAL: begin
				lim.pos = sel_sync_q[1] ? ext_pos_c : int_pos_c;
				lim.neg = sel_sync_q[0] ? ext_neg_c : int_neg_c;
			end
			SRC_ANALOG: lim = '{pos: analog_lim, neg: analog_lim};
			SRC_MIN_EXT_ANALOG: begin
				lim.pos = sel_sync_q[1] ? min_lim(ext_pos_c, analog_lim) : analog_lim;
				lim.neg = sel_sync_q[0] ? min_lim(ext_neg_c, analog_lim) : analog_lim;
			end
			SRC_SWITCH_INT_ANALOG: begin
				lim.pos = sel_sync_q[1] ? analog_lim : int_pos_c;
				lim.neg = sel_sync_q[0] ? analog_lim : int_neg_c;
			end
			default: lim = '{pos: int_pos_c, neg: int_neg_c};
		endcase
	end

	always_comb begin
		out_d = y_int;
		limited_d = 1'b0;
		if (!y_int[TORQUE_W-1] && y_int >= $signed({4'h0, lim.pos})) begin
			out_d = $signed({4'h0, lim.pos});
			limited_d = 1'b1;
		end else if (y_int[TORQUE_W-1] && -y_int >= $signed({4'h0, lim.neg})) begin
			out_d = -$signed({4'h0, lim.neg});
			limited_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= '0;
			limited_q <= 1'b0;
		end else begin
			out_q <= out_d;
			limited_q <= limited_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign torque_cmd_out = out_q;
	assign torque_limited_out = limited_q;
	assign gain_switch_condition_out = ctrl_q.gain_switch_condition;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_pos_clamp_value: assert property (
		(!y_int[TORQUE_W-1] && y_int > $signed({4'h0, lim.pos}))
		|=> torque_cmd_out == $signed({4'h0, $past(lim.pos)}))
		else $error("positive command not clamped to limit");
	chk_neg_clamp_value: assert property (
		(y_int[TORQUE_W-1] && -y_int > $signed({4'h0, lim.neg}))
		|=> torque_cmd_out == -$signed({4'h0, $past(lim.neg)}))
		else $error("negative command not clamped to limit");
	chk_pass_unchanged: assert property (
		(y_int < $signed({4'h0, lim.pos}) && -y_int < $signed({4'h0, lim.neg}))
		|=> torque_cmd_out == $past(y_int) && !torque_limited_out)
		else $error("unlimited command altered");
	chk_limit_ceiling: assert property (
		lim.pos <= LIMIT_CEILING && lim.neg <= LIMIT_CEILING
		&& lim.pos <= max_torque_q && lim.neg <= max_torque_q)
		else $error("active limit above ceiling");
	chk_src_internal: assert property (
		ctrl_q.limit_source_select == SRC_INTERNAL && int_pos_q <= max_torque_q
		|-> lim.pos == int_pos_q)
		else $error("internal source not used");
	chk_src_external: assert property (
		ctrl_q.limit_source_select == SRC_EXTERNAL && sel_sync_q[1]
		&& ext_pos_q <= max_torque_q |-> lim.pos == ext_pos_q)
		else $error("external positive limit not selected");
	chk_src_min_sel: assert property (
		ctrl_q.limit_source_select == SRC_MIN_EXT_ANALOG && sel_sync_q[1]
		|-> lim.pos <= analog_lim && lim.pos <= ext_pos_q)
		else $error("minimum source exceeds a bound");
	chk_src_switch_off: assert property (
		ctrl_q.limit_source_select == SRC_SWITCH_INT_ANALOG && !sel_sync_q[0]
		&& int_neg_q <= max_torque_q |-> lim.neg == int_neg_q)
		else $error("switching source ignores internal negative limit");
	chk_filter_switch: assert property (
		tick && use_f2 |=> f2_active_q)
		else $error("second filter not selected");
	chk_zero_tc_pass: assert property (
		tick && !use_f2 && filt1_tc_q == '0 |-> ##36 y_int == $past(torque_cmd_in, 36))
		else $error("zero time constant did not pass command");
	chk_limited_flag: assert property (
		limited_d |=> torque_limited_out ##0 (torque_cmd_out == $past(out_d)))
		else $error("limited flag missing");

	cov_source_min: cover property (
		ctrl_q.limit_source_select == SRC_MIN_EXT_ANALOG && limited_q);
	cov_filter_two: cover property (tick && use_f2);
	cov_neg_clamp: cover property (limited_q && out_q[TORQUE_W-1]);
endmodule

// ===== verif/torque_cmd_source.sv
/*
 * Model of the command source (upper computer or speed regulator).
 * Assumes the bench names the wanted command and a lag in hclk cycles.
 */
`timescale 1ns/1ps
module torque_cmd_source
	import torque_limit_pkg::*;
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire logic signed [torque_limit_pkg::TORQUE_W-1:0] cmd_req, // wanted command
	input wire logic [7:0] lag, // cycles before a new command shows
	output logic signed [torque_limit_pkg::TORQUE_W-1:0] torque_cmd // command to the block
);
	logic signed [TORQUE_W-1:0] pend_q;
	logic [7:0] cnt_q;

	// a new command restarts the lag so a slow source is also exercised
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 16'h0000;
			cnt_q <= 8'h00;
			torque_cmd <= 16'h0000;
		end else if (cmd_req != pend_q) begin
			pend_q <= cmd_req;
			cnt_q <= lag;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			torque_cmd <= pend_q;
		end
	end
endmodule

// ===== verif/test_torque_cmd_filter_limiter.sv
/*
 * Self-checking bench: AHB-Lite register access, filter and limit sources.
 * Assumes the design package and the command source model are compiled first.
 */
`timescale 1ns/1ps
module test_torque_cmd_filter_limiter;
	import torque_limit_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic signed [TORQUE_W-1:0] torque_cmd_in, analog_input_one, analog_input_two;
	logic signed [TORQUE_W-1:0] torque_cmd_out, cmd_req;
	logic positive_limit_select_in, negative_limit_select_in, gain_switch_cond_met;
	logic torque_limited_out;
	logic [3:0] gain_switch_condition_out;
	logic [7:0] lag;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;

	torque_cmd_filter_limiter uut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.torque_cmd_in(torque_cmd_in), .analog_input_one(analog_input_one),
		.analog_input_two(analog_input_two),
		.positive_limit_select_in(positive_limit_select_in),
		.negative_limit_select_in(negative_limit_select_in),
		.gain_switch_cond_met(gain_switch_cond_met),
		.gain_switch_condition_out(gain_switch_condition_out),
		.torque_cmd_out(torque_cmd_out), .torque_limited_out(torque_limited_out));

	torque_cmd_source src(.hclk(hclk), .hresetn(hresetn), .cmd_req(cmd_req), .lag(lag),
		.torque_cmd(torque_cmd_in));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic give_verdict();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
		cmp_count++;
		if (got !== want) begin
			$display("BAD %s expected %h seen %h", what, want, got);
			n_mismatch++;
		end
	endtask

	// one single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] want);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(what, want, q);
		check("hresp", 32'h00000000, {31'h00000000, hresp});
	endtask

	task automatic wait_change();
		logic [15:0] old;
		int n;
		old = torque_cmd_out;
		n = 0;
		do @(posedge hclk); while (torque_cmd_out === old && ++n < 1500);
		@(posedge hclk);
	endtask

	// 1500 cycles cover one 1250-cycle tick, the source lag and the pipeline
	task automatic run_case(input logic [2:0] s, input logic [1:0] ch, input logic ps, ns,
		input int a2, cmd, want, input logic lim);
		wr(ADDR_CTRL, {26'h0000000, ch, 1'b0, s});
		positive_limit_select_in <= ps;
		negative_limit_select_in <= ns;
		analog_input_two <= 16'(a2);
		cmd_req <= 16'(cmd);
		repeat (1500) @(posedge hclk);
		check("torque_cmd_out", 32'(want), 32'(torque_cmd_out));
		check("torque_limited_out", {31'h00000000, lim}, {31'h00000000, torque_limited_out});
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		analog_input_one = -16'sd700;
		analog_input_two = 16'sd600;
		positive_limit_select_in = 1'b0;
		negative_limit_select_in = 1'b0;
		gain_switch_cond_met = 1'b0;
		cmd_req = 16'h0000;
		lag = 8'h00;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk("ctrl", ADDR_CTRL, 32'h00000020);
		rd_chk("filt1_tc", ADDR_FILT1_TC, 32'h0000004f);
		rd_chk("filt2_tc", ADDR_FILT2_TC, 32'h0000004f);
		rd_chk("int_pos", ADDR_INT_POS, 32'h00000bb8);
		rd_chk("ext_neg", ADDR_EXT_NEG, 32'h00000bb8);
		rd_chk("unmapped", 8'h40, 32'h00000000);
		wr(ADDR_FILT2_TC, 32'h00001388);
		rd_chk("filt2_tc clip", ADDR_FILT2_TC, 32'h00000bb8);
		// step response of filter one with a time constant of one unit
		wr(ADDR_FILT1_TC, 32'h00000001);
		cmd_req <= 16'sd1000;
		wait_change();
		check("first step", 32'd500, 32'(torque_cmd_out));
		wait_change();
		check("second step", 32'd750, 32'(torque_cmd_out));
		wr(ADDR_FILT1_TC, 32'h00000000);
		wait_change();
		check("zero tc", 32'd1000, 32'(torque_cmd_out));
		// slow filter one, instant filter two
		wr(ADDR_FILT1_TC, 32'h00000bb8);
		wr(ADDR_FILT2_TC, 32'h00000000);
		wr(ADDR_CTRL, 32'h00000120);
		gain_switch_cond_met <= 1'b1;
		cmd_req <= 16'sd0;
		repeat (1500) @(posedge hclk);
		check("code zero keeps one", 32'h1, 32'(torque_cmd_out > 990));
		wr(ADDR_CTRL, 32'h00001120);
		repeat (1500) @(posedge hclk);
		check("filter two", 32'h0, 32'(torque_cmd_out));
		check("cond code", 32'h1, {28'h0000000, gain_switch_condition_out});
		rd_chk("status f2", ADDR_STATUS, 32'h0bb80200);
		gain_switch_cond_met <= 1'b0;
		cmd_req <= 16'sd1000;
		repeat (1500) @(posedge hclk);
		check("back to one", 32'h1, 32'(torque_cmd_out < 10));
		wr(ADDR_FILT1_TC, 32'h00000000);
		wr(ADDR_INT_POS, 32'h000003e8);
		wr(ADDR_INT_NEG, 32'h00000320);
		wr(ADDR_EXT_POS, 32'h000001f4);
		wr(ADDR_EXT_NEG, 32'h00000190);
		rd_chk("int_neg", ADDR_INT_NEG, 32'h00000320);
		lag <= 8'h40;
		run_case(3'h0, 2'h2, 1'b1, 1'b1, 600, 2000, 1000, 1'b1);
		run_case(3'h0, 2'h2, 1'b1, 1'b1, 600, -2000, -800, 1'b1);
		rd_chk("cmd_out", ADDR_CMD_OUT, 32'hfffffce0);
		run_case(3'h0, 2'h2, 1'b0, 1'b0, 600, 300, 300, 1'b0);
		run_case(3'h0, 2'h2, 1'b0, 1'b0, 600, 1000, 1000, 1'b1);
		run_case(3'h1, 2'h2, 1'b1, 1'b0, 600, 2000, 500, 1'b1);
		run_case(3'h1, 2'h2, 1'b0, 1'b0, 600, 2000, 1000, 1'b1);
		run_case(3'h1, 2'h2, 1'b0, 1'b1, 600, -2000, -400, 1'b1);
		rd_chk("status sel", ADDR_STATUS, 32'h03e80500);
		run_case(3'h1, 2'h2, 1'b0, 1'b0, 600, -2000, -800, 1'b1);
		run_case(3'h2, 2'h2, 1'b0, 1'b0, 600, 2000, 600, 1'b1);
		run_case(3'h2, 2'h1, 1'b0, 1'b0, 600, -2000, -700, 1'b1);
		run_case(3'h2, 2'h2, 1'b0, 1'b0, 4000, 5000, 3000, 1'b1);
		run_case(3'h3, 2'h2, 1'b0, 1'b0, 600, 2000, 600, 1'b1);
		run_case(3'h3, 2'h2, 1'b1, 1'b0, 600, 2000, 500, 1'b1);
		run_case(3'h3, 2'h2, 1'b1, 1'b0, 300, 2000, 300, 1'b1);
		run_case(3'h3, 2'h2, 1'b0, 1'b1, 600, -2000, -400, 1'b1);
		run_case(3'h3, 2'h2, 1'b0, 1'b0, 600, -2000, -600, 1'b1);
		run_case(3'h4, 2'h2, 1'b0, 1'b0, 600, 2000, 1000, 1'b1);
		run_case(3'h4, 2'h2, 1'b1, 1'b0, 600, 2000, 600, 1'b1);
		run_case(3'h4, 2'h2, 1'b0, 1'b0, 600, -2000, -800, 1'b1);
		run_case(3'h4, 2'h2, 1'b0, 1'b1, 600, -2000, -600, 1'b1);
		// an unknown source code leaves source four in force
		run_case(3'h7, 2'h2, 1'b1, 1'b0, 600, 2000, 600, 1'b1);
		wr(ADDR_MAX_TORQUE, 32'h000001c2);
		run_case(3'h0, 2'h2, 1'b0, 1'b0, 600, 2000, 450, 1'b1);
		rd_chk("status max", ADDR_STATUS, 32'h01c20100);
		give_verdict();
	end
endmodule
